// File: rtl/urf_pkg.sv
// Purpose: shared constants, states and state carriers of the uart receiver block
// Assumes: one clock domain, registers on a plain strobe port
// Notes: offsets are word indices on a 4-bit register address
`default_nettype none
package urf_pkg;
	localparam int FIFO_DEPTH = 16;
	localparam int PTR_W = 4;
	localparam int CNT_W = 5;
	localparam int ADDR_W = 4;
	// register offsets
	localparam logic [3:0] REG_DATA = 4'h0;
	localparam logic [3:0] REG_IER = 4'h1;
	localparam logic [3:0] REG_IIR = 4'h2;
	localparam logic [3:0] REG_FCR = 4'h3;
	localparam logic [3:0] REG_LCR = 4'h4;
	localparam logic [3:0] REG_MCR = 4'h5;
	localparam logic [3:0] REG_LSR = 4'h6;
	localparam logic [3:0] REG_DIV = 4'h7;
	localparam logic [3:0] REG_PWR = 4'h8;
	// field positions
	localparam int IER_RX = 0;
	localparam int IER_TX = 1;
	localparam int IER_LS = 2;
	localparam int FCR_EN = 0;
	localparam int FCR_RXCLR = 1;
	localparam int FCR_TXCLR = 2;
	localparam int FCR_TRIG = 6;
	localparam int LCR_PEN = 3;
	localparam int LCR_EVEN = 4;
	localparam int MCR_AFE = 5;
	localparam int PWR_RX = 0;
	localparam int PWR_TX = 1;
	// interrupt identification codes, highest priority first
	localparam logic [3:0] IIR_LS = 4'h6;
	localparam logic [3:0] IIR_TO = 4'hc;
	localparam logic [3:0] IIR_RDA = 4'h4;
	localparam logic [3:0] IIR_TX_HOLDING_EMPTY = 4'h2;
	localparam logic [3:0] IIR_NONE = 4'h1;
	// trigger levels for selector 0..3
	localparam logic [4:0] TRIG_L0 = 5'h01;
	localparam logic [4:0] TRIG_L1 = 5'h04;
	localparam logic [4:0] TRIG_L2 = 5'h08;
	localparam logic [4:0] TRIG_L3 = 5'h0e;
	// timing: 16 ticks per bit, start checked after 8 ticks
	localparam logic [3:0] SAMPLE_MID = 4'h7;
	localparam logic [3:0] SAMPLE_LAST = 4'hf;
	localparam logic [3:0] CHAR_BITS_MIN = 4'h8;
	localparam logic [10:0] TO_TICKS_PER_BIT = 11'h040;
	localparam logic [15:0] DIV_RESET = 16'h0001;
	localparam logic [1:0] PWR_RESET = 2'h0;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} urf_rx_e;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} urf_tx_e;
	typedef struct packed {
		logic [2:0] irq_enable_reg;
		logic fifoEn;
		logic [1:0] trig;
		logic [4:0] line_format_control;
		logic afe;
		logic [15:0] div;
		logic rxRun;
		logic txRun;
	} urf_regs_s;
	typedef struct packed {
		logic oe;
		logic pe;
		logic fe;
		logic bi;
	} urf_errs_s;
endpackage : urf_pkg
`default_nettype wire

// File: rtl/urf_uart.sv
// Purpose: uart receiver with 16-entry error-tagged fifo, transmitter and autoflow
// Assumes: inputs synchronous to core_clk, 16x tick from a divisor register
// Notes: all state lives in one packed struct, two comb and one clocked process
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`default_nettype none
module urf_uart
	import urf_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	input wire logic serialIn,
	output logic serialOut,
	input wire logic clearToSendIn_b,
	output logic requestToSendOut_b,
	output logic irqOut
);
	typedef struct packed {
		urf_regs_s regs;
		logic [FIFO_DEPTH-1:0][10:0] rxMem;
		logic [PTR_W-1:0] rxWr, rxRd;
		logic [CNT_W-1:0] rxCount;
		logic [FIFO_DEPTH-1:0][7:0] txMem;
		logic [PTR_W-1:0] txWr, txRd;
		logic [CNT_W-1:0] txCount;
		logic [15:0] baudCnt;
		logic tick;
		urf_rx_e rxState;
		logic [3:0] rxTicks;
		logic [2:0] rxBits;
		logic [7:0] rxShift;
		logic rxPar, rxZero, rxParErr;
		urf_errs_s errs;
		logic [10:0] toCnt;
		logic toPend;
		urf_tx_e txState;
		logic [3:0] txTicks;
		logic [2:0] txBits;
		logic [7:0] txShift;
		logic txPar, serialOut, rts_b, irq;
		logic [3:0] irq_ident_reg;
		logic [7:0] rdData;
	} urf_state_s;
	urf_state_s st, nx;

	////////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic logic [4:0] trigLevel(input logic [1:0] sel);
		case (sel)
			2'h0: trigLevel = TRIG_L0;
			2'h1: trigLevel = TRIG_L1;
			2'h2: trigLevel = TRIG_L2;
			default: trigLevel = TRIG_L3;
		endcase
	endfunction : trigLevel
	// any valid entry carrying an error tag
	function automatic logic anyTagged(input urf_state_s s);
		logic [PTR_W-1:0] idx;
		anyTagged = 1'b0;
		for (int i = 0; i < FIFO_DEPTH; i++) begin
			idx = s.rxRd + PTR_W'(i);
			if (CNT_W'(i) < s.rxCount && |s.rxMem[idx][10:8]) begin
				anyTagged = 1'b1;
			end
		end
	endfunction : anyTagged

	////////////////////////////////////////////////////////////////////////////
	// shared decode
	logic [4:0] trigFill;
	logic [CNT_W-1:0] capacity;
	logic [3:0] charBits;
	logic [10:0] toLimit, rxEntry;
	logic [2:0] lastBit;
	logic rxPush, rxPop, txPush, txPop, rxFull, stopOk;
	logic [7:0] rxAligned;
	logic lsInt, rdaInt, toInt, threInt, txAllEmpty;

	always_comb begin
		trigFill = trigLevel(st.regs.trig);
		capacity = st.regs.fifoEn ? CNT_W'(FIFO_DEPTH) : CNT_W'(1);
		charBits = CHAR_BITS_MIN + {2'h0, st.regs.line_format_control[1:0]};
		toLimit = {7'h00, charBits} * TO_TICKS_PER_BIT;
		lastBit = 3'h4 + {1'b0, st.regs.line_format_control[1:0]};
		rxFull = st.rxCount >= capacity;
		txAllEmpty = st.txCount == '0 && st.txState == TX_IDLE;
	end

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		nx = st;
		rxPush = 1'b0;
		rxPop = 1'b0;
		txPush = 1'b0;
		txPop = 1'b0;
		stopOk = serialIn;
		rxAligned = st.rxShift >> (2'h3 - st.regs.line_format_control[1:0]);
		rxEntry = '0;
		// 16x tick from the divisor; a zero divisor behaves as one
		if (st.baudCnt + 16'h0001 >= st.regs.div) begin
			nx.baudCnt = '0;
			nx.tick = 1'b1;
		end else begin
			nx.baudCnt = st.baudCnt + 16'h0001;
			nx.tick = 1'b0;
		end
		// register writes
		if (regWr) begin
			case (regAddr)
				REG_DATA: txPush = st.txCount < capacity; // full writes are dropped
				REG_IER: nx.regs.irq_enable_reg = regWrData[2:0];
				REG_FCR: begin
					nx.regs.fifoEn = regWrData[FCR_EN];
					nx.regs.trig = regWrData[FCR_TRIG +: 2];
				end
				REG_LCR: nx.regs.line_format_control = regWrData[4:0];
				REG_MCR: nx.regs.afe = regWrData[MCR_AFE];
				REG_DIV: nx.regs.div = {8'h00, regWrData};
				REG_PWR: begin
					nx.regs.rxRun = regWrData[PWR_RX];
					nx.regs.txRun = regWrData[PWR_TX];
				end
				default: ;
			endcase
		end
		// register reads, data appear in the following cycle
		if (regRd) begin
			case (regAddr)
				REG_DATA: begin
					nx.rdData = st.rxMem[st.rxRd][7:0];
					rxPop = st.rxCount != '0;
				end
				REG_IER: nx.rdData = {5'h00, st.regs.irq_enable_reg};
				REG_IIR: nx.rdData = {4'h0, st.irq_ident_reg};
				REG_FCR: nx.rdData = {st.regs.trig, 5'h00, st.regs.fifoEn};
				REG_LCR: nx.rdData = {3'h0, st.regs.line_format_control};
				REG_MCR: nx.rdData = {2'h0, st.regs.afe, 5'h00};
				REG_LSR: nx.rdData = {anyTagged(st), txAllEmpty, st.txCount == '0,
					st.errs.bi, st.errs.fe, st.errs.pe, st.errs.oe, st.rxCount != '0};
				REG_DIV: nx.rdData = st.regs.div[7:0];
				REG_PWR: nx.rdData = {6'h00, st.regs.txRun, st.regs.rxRun};
				default: nx.rdData = 8'h00;
			endcase
			// error flags clear on a status read; a new error below wins
			if (regAddr == REG_LSR) begin
				nx.errs = '0;
			end
		end

		// receiver sequencing, one step per tick
		if (!st.regs.rxRun) begin
			nx.rxState = RX_IDLE;
			nx.rxTicks = '0;
		end else if (st.tick) begin
			nx.rxTicks = st.rxTicks + 4'h1;
			case (st.rxState)
				RX_IDLE: begin
					nx.rxTicks = '0;
					if (!serialIn) begin
						nx.rxState = RX_START;
					end
				end
				RX_START: begin
					if (st.rxTicks == SAMPLE_MID) begin
						nx.rxTicks = '0;
						nx.rxBits = '0;
						nx.rxShift = '0;
						nx.rxPar = 1'b0;
						nx.rxZero = 1'b1;
						nx.rxParErr = 1'b0;
						nx.rxState = serialIn ? RX_IDLE : RX_DATA; // false start glitch
					end
				end
				RX_DATA: begin
					if (st.rxTicks == SAMPLE_LAST) begin
						nx.rxShift = {serialIn, st.rxShift[7:1]};
						nx.rxPar = st.rxPar ^ serialIn;
						nx.rxZero = st.rxZero & ~serialIn;
						nx.rxBits = st.rxBits + 3'h1;
						if (st.rxBits == lastBit) begin
							nx.rxState = st.regs.line_format_control[LCR_PEN] ? RX_PAR : RX_STOP;
						end
					end
				end
				RX_PAR: begin
					if (st.rxTicks == SAMPLE_LAST) begin
						nx.rxParErr = st.rxPar ^ serialIn ^ ~st.regs.line_format_control[LCR_EVEN];
						nx.rxZero = st.rxZero & ~serialIn;
						nx.rxState = RX_STOP;
					end
				end
				RX_STOP: begin
					if (st.rxTicks == SAMPLE_LAST) begin
						// only the first stop bit is checked
						rxEntry = {st.rxZero & ~stopOk, ~stopOk, st.rxParErr, rxAligned};
						rxPush = 1'b1;
						nx.rxState = RX_IDLE;
					end
				end
				default: nx.rxState = RX_IDLE;
			endcase
		end

		// receive fifo; a completed character into a full fifo is discarded unless a data read pops an entry in the same cycle
		if (rxPush && rxFull && !rxPop) begin
			nx.errs.oe = 1'b1;
		end else if (rxPush) begin
			nx.rxMem[st.rxWr] = rxEntry;
			nx.rxWr = st.rxWr + 4'h1;
			nx.errs.pe = nx.errs.pe | rxEntry[8];
			nx.errs.fe = nx.errs.fe | rxEntry[9];
			nx.errs.bi = nx.errs.bi | rxEntry[10];
		end
		if (rxPop) begin
			nx.rxRd = st.rxRd + 4'h1;
		end
		nx.rxCount = st.rxCount + CNT_W'(rxPush && !(rxFull && !rxPop)) - CNT_W'(rxPop);

		// receive time-out timer
		if (rxPush || rxPop || !st.regs.rxRun || st.rxCount == '0 || !st.regs.fifoEn) begin
			nx.toCnt = '0;
			nx.toPend = 1'b0;
		end else if (!st.toPend && st.tick) begin
			nx.toCnt = st.toCnt + 11'h001;
			nx.toPend = st.toCnt + 11'h001 >= toLimit;
		end

		// transmitter; clear-to-send gates only the start of a character
		if (!st.regs.txRun) begin
			nx.txState = TX_IDLE;
			nx.serialOut = 1'b1;
		end else if (st.txState == TX_IDLE) begin
			nx.serialOut = 1'b1;
			if (st.txCount != '0 && (!st.regs.afe || !clearToSendIn_b)) begin
				txPop = 1'b1;
				nx.txShift = st.txMem[st.txRd];
				nx.txPar = 1'b0;
				nx.txTicks = '0;
				nx.txBits = '0;
				nx.txState = TX_START;
			end
		end else if (st.tick) begin
			nx.txTicks = st.txTicks + 4'h1;
			case (st.txState)
				TX_START: nx.serialOut = 1'b0;
				TX_DATA: nx.serialOut = st.txShift[0];
				TX_PAR: nx.serialOut = st.txPar ^ ~st.regs.line_format_control[LCR_EVEN];
				default: nx.serialOut = 1'b1;
			endcase
			if (st.txTicks == SAMPLE_LAST) begin
				case (st.txState)
					TX_START: nx.txState = TX_DATA;
					TX_DATA: begin
						nx.txShift = {1'b0, st.txShift[7:1]};
						nx.txPar = st.txPar ^ st.txShift[0];
						nx.txBits = st.txBits + 3'h1;
						if (st.txBits == lastBit) begin
							nx.txState = st.regs.line_format_control[LCR_PEN] ? TX_PAR : TX_STOP;
						end
					end
					TX_PAR: nx.txState = TX_STOP;
					default: nx.txState = TX_IDLE;
				endcase
			end
		end

		// transmit fifo
		if (txPush) begin
			nx.txMem[st.txWr] = regWrData;
			nx.txWr = st.txWr + 4'h1;
		end
		if (txPop) begin
			nx.txRd = st.txRd + 4'h1;
		end
		nx.txCount = st.txCount + CNT_W'(txPush) - CNT_W'(txPop);

		// fifo clear controls act after this cycle's traffic
		if (regWr && regAddr == REG_FCR && regWrData[FCR_RXCLR]) begin
			nx.rxWr = '0;
			nx.rxRd = '0;
			nx.rxCount = '0;
		end
		if (regWr && regAddr == REG_FCR && regWrData[FCR_TXCLR]) begin
			nx.txWr = '0;
			nx.txRd = '0;
			nx.txCount = '0;
		end

		// interrupt identification; disabled sources never show
		lsInt = st.regs.irq_enable_reg[IER_LS] && |st.errs;
		rdaInt = st.regs.irq_enable_reg[IER_RX] && (st.regs.fifoEn ? st.rxCount >= trigFill
			: st.rxCount != '0);
		toInt = st.regs.irq_enable_reg[IER_RX] && st.toPend;
		threInt = st.regs.irq_enable_reg[IER_TX] && st.txCount == '0;
		// no source looks at clear-to-send
		if (lsInt) begin
			nx.irq_ident_reg = IIR_LS;
		end else if (toInt) begin
			nx.irq_ident_reg = IIR_TO;
		end else if (rdaInt) begin
			nx.irq_ident_reg = IIR_RDA;
		end else if (threInt) begin
			nx.irq_ident_reg = IIR_TX_HOLDING_EMPTY;
		end else begin
			nx.irq_ident_reg = IIR_NONE;
		end
		nx.irq = lsInt | toInt | rdaInt | threInt;

		// request-to-send; trigger 14 leaves room for one late character
		nx.rts_b = st.regs.afe && (st.rxCount >= trigFill
			|| (st.rts_b && st.regs.trig != 2'h3 && st.rxCount != '0));
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
			st.regs.div <= DIV_RESET;
			st.regs.rxRun <= PWR_RESET[PWR_RX];
			st.regs.txRun <= PWR_RESET[PWR_TX];
			st.serialOut <= 1'b1;
			st.irq_ident_reg <= IIR_NONE;
		end else begin
			st <= nx;
		end
	end

	assign regRdData = st.rdData;
	assign serialOut = st.serialOut;
	assign requestToSendOut_b = st.rts_b;
	assign irqOut = st.irq;

	////////////////////////////////////////////////////////////////////////////
	// checks
	AST_RX_DEPTH: assert property (@(posedge core_clk) disable iff (!rst_b)
		(!st.regs.fifoEn |-> st.rxCount <= 5'h01) and (st.rxCount <= 5'h10))
		else $error("receive fill beyond capacity");
	AST_DR_SET: assert property (@(posedge core_clk) disable iff (!rst_b)
		(rxPush && st.rxCount == '0 && !(regWr && regAddr == REG_FCR)) |=> st.rxCount == 5'h01)
		else $error("first character did not set data present");
	AST_OVERRUN: assert property (@(posedge core_clk) disable iff (!rst_b)
		(rxPush && rxFull && !rxPop && !(regWr && regAddr == REG_FCR))
		|=> st.errs.oe && $stable(st.rxMem) && $stable(st.rxCount))
		else $error("overrun lost flag or overwrote data");
	AST_LS_FIRST: assert property (@(posedge core_clk) disable iff (!rst_b)
		(st.regs.irq_enable_reg[IER_LS] && |st.errs) |=> st.irq_ident_reg == IIR_LS)
		else $error("line status not given priority");
	AST_POLL_QUIET: assert property (@(posedge core_clk) disable iff (!rst_b)
		!st.regs.irq_enable_reg[IER_RX] |=> (st.irq_ident_reg != IIR_RDA && st.irq_ident_reg != IIR_TO))
		else $error("poll mode produced a receive indication");
	AST_TO_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_b)
		(rxPop || rxPush) |=> !st.toPend && st.toCnt == '0)
		else $error("time-out not cleared by fifo traffic");
	AST_RTS_DROP: assert property (@(posedge core_clk) disable iff (!rst_b)
		(st.regs.afe && st.rxCount >= trigFill) |=> requestToSendOut_b)
		else $error("request-to-send held at trigger level");
	AST_CTS_GATE: assert property (@(posedge core_clk) disable iff (!rst_b)
		(st.txState == TX_IDLE && st.regs.afe && clearToSendIn_b) |=> st.txState == TX_IDLE)
		else $error("character started without clear-to-send");
	AST_TX_HOLDING_EMPTY_INT: assert property (@(posedge core_clk) disable iff (!rst_b)
		(st.regs.irq_enable_reg == 3'h2 && st.txCount == '0) |=> (st.irq_ident_reg == IIR_TX_HOLDING_EMPTY && irqOut))
		else $error("transmit-empty interrupt missing");
endmodule : urf_uart
`default_nettype wire

// File: sim/urf_far_end.sv
// Purpose: far-end serial peer: frames characters onto the receive line, decodes serialOut
// Assumes: divisor 1, so one bit lasts 16 core_clk cycles
// Notes: waits for request-to-send unless told to push one extra character
`default_nettype none
module urf_far_end
	import urf_pkg::*;
(
	input wire logic core_clk,
	output logic serialIn,
	input wire logic serialOut,
	output logic clearToSendIn_b,
	input wire logic requestToSendOut_b
);
	timeunit 1ns;
	timeprecision 1ns;
	int nBits = 8;
	logic parEn = 1'b0;
	logic [7:0] got[$];
	// idle line high, transmitter allowed
	initial begin
		serialIn = 1'b1;
		clearToSendIn_b = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// one bit period on the receive line
	task automatic bitOut(input logic b);
		serialIn <= b;
		repeat (16) @(posedge core_clk);
	endtask : bitOut
	// even parity; badPar flips it, badStop sends a low stop bit then idles
	task automatic sendChar(input logic [7:0] d, input logic badPar, input logic badStop,
		input logic ignoreRts);
		logic p;
		int i;
		p = badPar;
		for (i = 0; i < nBits; i++) p ^= d[i];
		while (requestToSendOut_b && !ignoreRts) @(posedge core_clk);
		bitOut(1'b0);
		for (i = 0; i < nBits; i++) bitOut(d[i]);
		if (parEn) bitOut(p);
		bitOut(!badStop);
		if (badStop) bitOut(1'b1);
	endtask : sendChar
	// only moved between characters, so always well before a stop midpoint
	task automatic setCts(input logic v);
		clearToSendIn_b <= v;
	endtask : setCts
	// decode serialOut at bit centres, same format as the receive side
	initial forever begin
		logic [7:0] r;
		int i;
		@(negedge serialOut);
		repeat (8) @(posedge core_clk);
		r = 8'h00;
		for (i = 0; i < nBits; i++) begin
			repeat (16) @(posedge core_clk);
			r[i] = serialOut;
		end
		if (parEn) repeat (16) @(posedge core_clk);
		repeat (16) @(posedge core_clk);
		got.push_back(r);
	end
endmodule : urf_far_end
`default_nettype wire

// File: sim/testbench.sv
// Purpose: self-checking bench for the uart receiver, fifo servicing and autoflow
// Assumes: divisor left at 1, far-end model on the serial and handshake pins
// Notes: registered pins are looked at two falling edges after their cause
`default_nettype none
module testbench
	import urf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk, rst_b, regWr, regRd, serialIn, serialOut, clearToSendIn_b;
	logic requestToSendOut_b, irqOut;
	logic [3:0] regAddr;
	logic [7:0] regWrData, regRdData, v;
	int miscompares, nTests, i;
	logic [7:0] eM[3] = '{8'hff, 8'hff, 8'hff};
	logic [7:0] eV[3] = '{8'he5, 8'he9, 8'hf9};
	// 50 MHz clock
	initial core_clk = 1'b0;
	always #10 core_clk = ~core_clk;
	urf_uart urf_uart_inst (.core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.serialIn(serialIn), .serialOut(serialOut), .clearToSendIn_b(clearToSendIn_b),
		.requestToSendOut_b(requestToSendOut_b), .irqOut(irqOut));
	urf_far_end urf_far_end_inst (.core_clk(core_clk), .serialIn(serialIn),
		.serialOut(serialOut), .clearToSendIn_b(clearToSendIn_b),
		.requestToSendOut_b(requestToSendOut_b));
	////////////////////////////////////////////////////////////////////////////////
	task automatic testDone();
		$display("comparisons %0d mismatches %0d", nTests, miscompares);
		if (miscompares == 0 && nTests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : testDone
	task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
		nTests++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask : cmp
	// strobes drop before the next call, so no double drive in one step
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
		@(posedge core_clk);
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		@(negedge core_clk);
		d = regRdData;
		@(posedge core_clk);
	endtask : rd
	task automatic rdc(input string nm, input logic [3:0] a, input logic [7:0] m,
		input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		cmp(nm, e, d & m);
	endtask : rdc
	// irq and rts lag their cause by a registered cycle
	task automatic pins(input logic eIrq, input logic eRts);
		repeat (2) @(negedge core_clk);
		cmp("irqOut", {7'h00, eIrq}, {7'h00, irqOut});
		cmp("requestToSendOut_b", {7'h00, eRts}, {7'h00, requestToSendOut_b});
		@(posedge core_clk);
	endtask : pins
	task automatic snd(input logic [7:0] d);
		urf_far_end_inst.sendChar(d, 1'b0, 1'b0, 1'b0);
	endtask : snd
	////////////////////////////////////////////////////////////////////////////////
	// hang guard: the whole sequence needs about 11k cycles
	initial begin
		repeat (40000) @(posedge core_clk);
		miscompares++;
		testDone();
	end
	// main sequence
	initial begin
		regAddr = 4'h0;
		regWrData = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		rst_b = 1'b0;
		miscompares = 0;
		nTests = 0;
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		pins(1'b0, 1'b0);
		cmp("serialOut", 8'h01, {7'h00, serialOut});
		wr(REG_PWR, 8'h03);
		wr(REG_IER, 8'h01);
		$display("test reset done");
		// word lengths 5..8 with even parity, single holding slot
		for (i = 0; i < 4; i++) begin
			wr(REG_LCR, 8'h18 | 8'(i));
			urf_far_end_inst.nBits = 5 + i;
			urf_far_end_inst.parEn = 1'b1;
			snd(8'ha5);
			pins(1'b1, 1'b0);
			rdc("lsr", REG_LSR, 8'hff, 8'h61);
			rdc("data", REG_DATA, 8'hff >> (3 - i), 8'ha5 & (8'hff >> (3 - i)));
			pins(1'b0, 1'b0);
		end
		$display("test format done");
		// bad parity, low stop bit, break: all-zero frame
		wr(REG_IER, 8'h05);
		for (i = 0; i < 3; i++) begin
			urf_far_end_inst.sendChar(i == 2 ? 8'h00 : 8'h3c, i == 0, i != 0, 1'b0);
			rdc("iir", REG_IIR, 8'h0f, {4'h0, IIR_LS});
			rdc("lsr", REG_LSR, eM[i], eV[i]);
			rd(REG_DATA, v);
		end
		// odd parity: far end flips its even bit, so no error is due
		wr(REG_LCR, 8'h0b);
		urf_far_end_inst.sendChar(8'h3c, 1'b1, 1'b0, 1'b0);
		rdc("lsr", REG_LSR, 8'hff, 8'h61);
		rdc("data", REG_DATA, 8'hff, 8'h3c);
		repeat (200) @(posedge core_clk);
		rd(REG_DATA, v);
		rd(REG_LSR, v);
		pins(1'b0, 1'b0);
		$display("test errors done");
		// fifo trigger 4, fill to 16, one overrun, drain in order
		wr(REG_FCR, 8'h47);
		wr(REG_IER, 8'h01);
		wr(REG_LCR, 8'h03);
		urf_far_end_inst.nBits = 8;
		urf_far_end_inst.parEn = 1'b0;
		for (i = 0; i < 17; i++) begin
			snd(8'h10 + 8'(i));
			if (i < 16) pins(i >= 3, 1'b0);
		end
		rdc("lsr", REG_LSR, 8'h03, 8'h03);
		for (i = 0; i < 16; i++) begin
			rdc("data", REG_DATA, 8'hff, 8'h10 + 8'(i));
			pins(i < 12, 1'b0);
		end
		rdc("lsr", REG_LSR, 8'h01, 8'h00);
		$display("test fifo done");
		// time-out: 4 character times of 11 bits, then poll mode stays silent
		snd(8'h77);
		repeat (600) @(posedge core_clk);
		pins(1'b0, 1'b0);
		repeat (150) @(posedge core_clk);
		pins(1'b1, 1'b0);
		rdc("iir", REG_IIR, 8'h0f, {4'h0, IIR_TO});
		rdc("data", REG_DATA, 8'hff, 8'h77);
		pins(1'b0, 1'b0);
		wr(REG_IER, 8'h00);
		for (i = 0; i < 4; i++) snd(8'h20);
		repeat (750) @(posedge core_clk);
		pins(1'b0, 1'b0);
		rdc("iir", REG_IIR, 8'h0f, {4'h0, IIR_NONE});
		wr(REG_FCR, 8'h43);
		rdc("lsr", REG_LSR, 8'h01, 8'h00);
		$display("test timeout done");
		// autoflow request-to-send at trigger 1, 8 and 14
		wr(REG_MCR, 8'h20);
		wr(REG_FCR, 8'h01);
		snd(8'h55);
		pins(1'b0, 1'b1);
		rd(REG_DATA, v);
		pins(1'b0, 1'b0);
		wr(REG_FCR, 8'h81);
		for (i = 0; i < 8; i++) snd(8'h30 + 8'(i));
		pins(1'b0, 1'b1);
		urf_far_end_inst.sendChar(8'h38, 1'b0, 1'b0, 1'b1);
		rdc("lsr", REG_LSR, 8'h03, 8'h01);
		for (i = 0; i < 9; i++) begin
			rdc("data", REG_DATA, 8'hff, 8'h30 + 8'(i));
			pins(1'b0, i < 8);
		end
		wr(REG_FCR, 8'hc1);
		for (i = 0; i < 14; i++) snd(8'h40);
		pins(1'b0, 1'b1);
		rd(REG_DATA, v);
		pins(1'b0, 1'b0);
		wr(REG_FCR, 8'hc3);
		// receiver reset keeps stored characters
		snd(8'h6b);
		wr(REG_PWR, 8'h02);
		wr(REG_PWR, 8'h03);
		rdc("data", REG_DATA, 8'hff, 8'h6b);
		$display("test autoflow done");
		// transmit held by clear-to-send, released later
		wr(REG_IER, 8'h02);
		pins(1'b1, 1'b0);
		rdc("iir", REG_IIR, 8'h0f, {4'h0, IIR_TX_HOLDING_EMPTY});
		urf_far_end_inst.setCts(1'b1);
		wr(REG_DATA, 8'h5a);
		repeat (300) @(posedge core_clk);
		pins(1'b0, 1'b0);
		rdc("lsr", REG_LSR, 8'h60, 8'h00);
		cmp("txCount", 8'h00, 8'(urf_far_end_inst.got.size()));
		urf_far_end_inst.setCts(1'b0);
		repeat (250) @(posedge core_clk);
		cmp("txChar", 8'h5a, urf_far_end_inst.got[0]);
		rdc("lsr", REG_LSR, 8'h60, 8'h60);
		pins(1'b1, 1'b0);
		$display("test transmit done");
		testDone();
	end
endmodule : testbench
`default_nettype wire
